// ===== include/ptc_params.svh
// offsets, field positions, reset values and counts of the paper tape word controller
// assumes a 32-bit register port with word-aligned byte addresses
`ifndef PTC_PARAMS_SVH
`define PTC_PARAMS_SVH

// ==========================================================
// register map
`define PTC_OFS_STATUS  8'h00
`define PTC_OFS_FAULT   8'h04
`define PTC_OFS_CTRL    8'h08
`define PTC_OFS_ORDER   8'h0C

// ==========================================================
// fields
`define PTC_ST_BUSY       0
`define PTC_ST_ZERO       1
`define PTC_CTRL_MODE_LO  0
`define PTC_CTRL_MODE_HI  1
`define PTC_CTRL_SKIP     2
`define PTC_CTRL_BYPASS   3
`define PTC_ORD_CNT_HI    7
`define PTC_ORD_PUNCH     8
`define PTC_ORD_REJECT    0

// ==========================================================
// reset values and counts
`define PTC_CTRL_RST      4'h0
`define PTC_STOP_CHAR     6'h3A
`define PTC_CHARS_PER_WD  4'h8
`define PTC_LAST_CHAR     3'h7
`endif

// ===== include/ptc_pkg.sv
// types of the paper tape word controller
// assumes nothing beyond a SystemVerilog compiler
package ptc_pkg;

  typedef enum logic [1:0] {
    PTC_MODE_FIVE  = 2'b00,
    PTC_MODE_SIX   = 2'b01,
    PTC_MODE_SEVEN = 2'b10,
    PTC_MODE_EIGHT = 2'b11
  } ptc_mode_t;

  typedef enum logic [2:0] {
    PTC_IDLE     = 3'b000,
    PTC_RD_WAIT  = 3'b001,
    PTC_RD_CHAR  = 3'b010,
    PTC_RD_STORE = 3'b011,
    PTC_PU_FETCH = 3'b100,
    PTC_PU_CHAR  = 3'b101,
    PTC_PU_OUT   = 3'b110
  } ptc_state_t;

endpackage : ptc_pkg

// ===== src/ptc_word_ctrl.sv
// paper tape controller on the single word channel: frames to words and back
// assumes synchronous reader, punch and io bus path handshakes on mclk_i
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "ptc_params.svh"

// What this block does
// - five-level frame gets zero top bit
// - seven-bit frame carries odd parity on channel seven
// - eight-bit frame splits: 0000+ch7,8 then ch1-6
// - accept order only if available and idle
// - busy sets on accept, clears at end
// - octal 72 ends a read order
// - stop-skip switch on ignores stop characters
// - blank read frames are discarded silently
// - holding register checks stop, parity, strips parity
// - read characters shift into low six bits
// - eight chars or stop: store word, clear
// - read store decrements count, zero ends order
// - punch word gives top six bits, shifts left
// - punch gets character, odd parity in seven-bit
// - punch eight chars, decrement, fetch or finish
// - parity error at stop: end, no store
// - parity error at bypass: carry on
// - no parity check while punching
// - stop character stored with partial word, release
// - unfilled positions of early word are zero
// - two-bit status: busy, words-left zero
// - fault bit set on parity error
module ptc_word_ctrl
  import ptc_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic        mech_avail_i,
  input  wire logic        rdr_valid_i,
  input  wire logic [7:0]  rdr_frame_i,
  output logic             rdr_ready_o,
  output logic             pun_valid_o,
  output logic      [7:0]  pun_frame_o,
  input  wire logic        pun_ready_i,
  output logic             mem_wr_valid_o,
  output logic      [47:0] mem_wr_data_o,
  input  wire logic        mem_wr_ready_i,
  output logic             mem_rd_req_o,
  input  wire logic        mem_rd_valid_i,
  input  wire logic [47:0] mem_rd_data_i
);

  // ==========================================================
  // state
  ptc_state_t  state_q, state_d;
  logic [47:0] word_q, word_d;
  logic [6:0]  hold_q, hold_d;       // bit 6 is the parity slot
  logic [5:0]  pend_q, pend_d;       // second character of an eight-bit frame
  logic        pend_v_q, pend_v_d;
  logic [3:0]  nchar_q, nchar_d;
  logic [7:0]  left_q, left_d;
  logic        stop_q, stop_d;
  logic        fault_q, fault_d;
  logic        rej_q, rej_d;
  logic [3:0]  ctrl_q, ctrl_d;
  logic [31:0] rdata_q, rdata_d;

  ptc_mode_t mode;
  logic      skip_stop;
  logic      par_bypass;
  logic      order_wr;
  logic      accept;
  logic      par_err;
  logic      is_stop;
  logic      blank;
  logic [5:0] in_char;
  logic [6:0] in_hold;

  assign mode       = ptc_mode_t'(ctrl_q[`PTC_CTRL_MODE_HI:`PTC_CTRL_MODE_LO]);
  assign skip_stop  = ctrl_q[`PTC_CTRL_SKIP];
  assign par_bypass = ctrl_q[`PTC_CTRL_BYPASS];
  assign order_wr   = ce_i && reg_wr_i && (reg_addr_i == `PTC_OFS_ORDER);
  // a zero count is refused as well; it would wrap and run 256 words
  assign accept     = order_wr && mech_avail_i && (state_q == PTC_IDLE)
                      && (reg_wdata_i[`PTC_ORD_CNT_HI:0] != 8'h00);

  // ==========================================================
  // frame to character
  always_comb begin
    blank   = 1'b1;
    in_char = 6'h00;
    in_hold = 7'h00;
    case (mode)
      PTC_MODE_FIVE: begin
        blank   = (rdr_frame_i[4:0] == 5'h00);
        in_char = {1'b0, rdr_frame_i[4:0]};
      end
      PTC_MODE_SIX: begin
        blank   = (rdr_frame_i[5:0] == 6'h00);
        in_char = rdr_frame_i[5:0];
      end
      PTC_MODE_SEVEN: begin
        blank   = (rdr_frame_i[6:0] == 7'h00);
        in_char = rdr_frame_i[5:0];
      end
      PTC_MODE_EIGHT: begin
        blank   = (rdr_frame_i == 8'h00);
        in_char = {4'h0, rdr_frame_i[7:6]};
      end
      default: begin
        blank   = 1'b1;
        in_char = 6'h00;
      end
    endcase
    in_hold = {(mode == PTC_MODE_SEVEN) && rdr_frame_i[6], in_char};
  end

  // parity only judged on reads, the punch side makes its own bit
  assign par_err = (state_q == PTC_RD_CHAR) && (mode == PTC_MODE_SEVEN)
                   && !(^hold_q);
  assign is_stop = (hold_q[5:0] == `PTC_STOP_CHAR) && !skip_stop;

  // ==========================================================
  // next state
  always_comb begin
    state_d  = state_q;
    word_d   = word_q;
    hold_d   = hold_q;
    pend_d   = pend_q;
    pend_v_d = pend_v_q;
    nchar_d  = nchar_q;
    left_d   = left_q;
    stop_d   = stop_q;
    fault_d  = fault_q;
    rej_d    = rej_q;
    ctrl_d   = ctrl_q;
    rdata_d  = 32'h0000_0000;

    if (ce_i && reg_wr_i && (reg_addr_i == `PTC_OFS_CTRL)) begin
      ctrl_d = reg_wdata_i[3:0];
    end
    if (ce_i && reg_rd_i) begin
      case (reg_addr_i)
        `PTC_OFS_STATUS: rdata_d = {30'h0, (left_q == 8'h00),
                                   (state_q != PTC_IDLE)};
        `PTC_OFS_FAULT:  rdata_d = {31'h0, fault_q};
        `PTC_OFS_CTRL:   rdata_d = {28'h0, ctrl_q};
        `PTC_OFS_ORDER:  rdata_d = {31'h0, rej_q};
        default:         rdata_d = 32'h0000_0000;
      endcase
    end

    if (order_wr) begin
      rej_d = !accept;
    end

    case (state_q)
      PTC_IDLE: begin
        if (accept) begin
          fault_d  = 1'b0;
          left_d   = reg_wdata_i[`PTC_ORD_CNT_HI:0];
          word_d   = 48'h0;
          nchar_d  = 4'h0;
          stop_d   = 1'b0;
          pend_v_d = 1'b0;
          state_d  = reg_wdata_i[`PTC_ORD_PUNCH] ? PTC_PU_FETCH
                                                : PTC_RD_WAIT;
        end
      end
      PTC_RD_WAIT: begin
        if (ce_i && rdr_valid_i && !blank) begin
          hold_d   = in_hold;
          pend_d   = rdr_frame_i[5:0];
          pend_v_d = (mode == PTC_MODE_EIGHT);
          state_d  = PTC_RD_CHAR;
        end
      end
      PTC_RD_CHAR: begin
        if (ce_i) begin
          if (par_err) begin
            fault_d = 1'b1;
          end
          if (par_err && !par_bypass) begin
            state_d = PTC_IDLE;
          end else begin
            word_d  = {word_q[41:0], hold_q[5:0]};
            nchar_d = nchar_q + 4'h1;
            stop_d  = is_stop;
            if (is_stop || (nchar_q == 4'(`PTC_CHARS_PER_WD - 4'h1))) begin
              state_d = PTC_RD_STORE;
            end else if (pend_v_q) begin
              hold_d   = {1'b1, pend_q};
              pend_v_d = 1'b0;
            end else begin
              state_d = PTC_RD_WAIT;
            end
          end
        end
      end
      PTC_RD_STORE: begin
        if (ce_i && mem_wr_ready_i) begin
          word_d  = 48'h0;
          nchar_d = 4'h0;
          left_d  = left_q - 8'h01;
          if (stop_q || (left_q == 8'h01)) begin
            state_d = PTC_IDLE;
          end else if (pend_v_q) begin
            hold_d   = {1'b1, pend_q};
            pend_v_d = 1'b0;
            state_d  = PTC_RD_CHAR;
          end else begin
            state_d = PTC_RD_WAIT;
          end
        end
      end
      PTC_PU_FETCH: begin
        if (ce_i && mem_rd_valid_i) begin
          word_d  = mem_rd_data_i;
          nchar_d = 4'h0;
          state_d = PTC_PU_CHAR;
        end
      end
      PTC_PU_CHAR: begin
        if (ce_i) begin
          hold_d  = {~^word_q[47:42], word_q[47:42]};
          word_d  = {word_q[41:0], 6'h00};
          state_d = PTC_PU_OUT;
        end
      end
      PTC_PU_OUT: begin
        if (ce_i && pun_ready_i) begin
          nchar_d = nchar_q + 4'h1;
          if (nchar_q[2:0] == `PTC_LAST_CHAR) begin
            left_d  = left_q - 8'h01;
            state_d = (left_q == 8'h01) ? PTC_IDLE : PTC_PU_FETCH;
          end else begin
            state_d = PTC_PU_CHAR;
          end
        end
      end
      default: state_d = PTC_IDLE;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_q  <= PTC_IDLE;
      word_q   <= 48'h0;
      hold_q   <= 7'h00;
      pend_q   <= 6'h00;
      pend_v_q <= 1'b0;
      nchar_q  <= 4'h0;
      left_q   <= 8'h00;
      stop_q   <= 1'b0;
      fault_q  <= 1'b0;
      rej_q    <= 1'b0;
      ctrl_q   <= `PTC_CTRL_RST;
      rdata_q  <= 32'h0000_0000;
    end else if (ce_i) begin
      state_q  <= state_d;
      word_q   <= word_d;
      hold_q   <= hold_d;
      pend_q   <= pend_d;
      pend_v_q <= pend_v_d;
      nchar_q  <= nchar_d;
      left_q   <= left_d;
      stop_q   <= stop_d;
      fault_q  <= fault_d;
      rej_q    <= rej_d;
      ctrl_q   <= ctrl_d;
      rdata_q  <= rdata_d;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata_o    = rdata_q;
  assign rdr_ready_o    = (state_q == PTC_RD_WAIT);
  assign mem_wr_valid_o = (state_q == PTC_RD_STORE);
  assign mem_wr_data_o  = word_q;
  assign mem_rd_req_o   = (state_q == PTC_PU_FETCH);
  assign pun_valid_o    = (state_q == PTC_PU_OUT);

  always_comb begin
    case (mode)
      PTC_MODE_FIVE:  pun_frame_o = {3'h0, hold_q[4:0]};
      PTC_MODE_SEVEN: pun_frame_o = {1'b0, hold_q};
      default:        pun_frame_o = {2'h0, hold_q[5:0]};
    endcase
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_accept;
    accept;
  endsequence

  sequence s_store;
    ce_i && mem_wr_valid_o && mem_wr_ready_i;
  endsequence

  chk_order_refused: assert property (order_wr && !accept |=> rej_q)
    else $error("refused order not flagged");
  chk_order_busy: assert property (s_accept |=> (state_q != PTC_IDLE) && !fault_q)
    else $error("accepted order not busy");
  chk_count_load: assert property (s_accept |=> left_q == $past(reg_wdata_i[7:0]))
    else $error("words left not loaded");
  chk_blank_drop: assert property (ce_i && rdr_ready_o && rdr_valid_i && blank
                                   |=> state_q == PTC_RD_WAIT)
    else $error("blank frame not discarded");
  chk_parity_stop: assert property (ce_i && par_err && !par_bypass
                                    |=> state_q == PTC_IDLE && fault_q && !mem_wr_valid_o)
    else $error("parity stop misbehaves");
  chk_word_shift: assert property (ce_i && state_q == PTC_RD_CHAR
                   && !(par_err && !par_bypass)
                   |=> word_q == {$past(word_q[41:0]), $past(hold_q[5:0])})
    else $error("character not shifted in");
  chk_store_clear: assert property (s_store |=> word_q == 48'h0
                    && left_q == $past(left_q) - 8'h01)
    else $error("store did not clear or count");
  chk_stop_end: assert property (s_store ##0 stop_q |=> state_q == PTC_IDLE)
    else $error("stop character did not end read");
  chk_punch_par: assert property (pun_valid_o && mode == PTC_MODE_SEVEN
                  |-> ^pun_frame_o[6:0])
    else $error("punched frame parity even");
  chk_punch_shift: assert property (ce_i && state_q == PTC_PU_CHAR
                    |=> hold_q[5:0] == $past(word_q[47:42]) && word_q[5:0] == 6'h00)
    else $error("punch character not taken from top");

  sequence s_take;
    ce_i && rdr_ready_o && rdr_valid_i && !blank;
  endsequence

  chk_five_top: assert property (s_take ##0 (mode == PTC_MODE_FIVE)
                 |=> hold_q[5:0] == {1'b0, $past(rdr_frame_i[4:0])})
    else $error("five-level character has top bit set");
  chk_eight_split: assert property (s_take ##0 (mode == PTC_MODE_EIGHT)
                    |=> hold_q[5:0] == {4'h0, $past(rdr_frame_i[7:6])}
                        && pend_q == $past(rdr_frame_i[5:0]) && pend_v_q)
    else $error("eight-bit frame not split in two");
  chk_punch_count: assert property (ce_i && pun_valid_o && pun_ready_i
                    && (nchar_q[2:0] == `PTC_LAST_CHAR) |=> left_q == $past(left_q) - 8'h01)
    else $error("words left not counted after punch");

endmodule // ptc_word_ctrl

// ===== bench/ptc_far.sv
// far side of the tape controller: reader, punch and memory on the io bus path
// assumes the bench loads tape, src and slow through hierarchy while idle
`timescale 1ns/1ps
module ptc_far (
  input  wire logic        mclk_i,
  output logic             rdr_valid_o,
  output logic      [7:0]  rdr_frame_o,
  input  wire logic        rdr_ready_i,
  input  wire logic        pun_valid_i,
  input  wire logic [7:0]  pun_frame_i,
  output logic             pun_ready_o,
  input  wire logic        mem_wr_valid_i,
  input  wire logic [47:0] mem_wr_data_i,
  output logic             mem_wr_ready_o,
  input  wire logic        mem_rd_req_i,
  output logic             mem_rd_valid_o,
  output logic      [47:0] mem_rd_data_o
);
  logic [7:0]  tape [65];
  logic [47:0] src  [4];
  logic [47:0] mw   [8];
  logic [7:0]  pf   [32];
  int          tn, tp, ri, mn, pn;
  logic        slow;
  logic [1:0]  cyc;
  logic        ok;

  // ======
  // answers
  // slow mode answers one cycle in four
  assign ok          = !slow || (cyc == 2'h3);
  assign rdr_valid_o = (tp < tn) && ok;
  // a line not offered shows the inverse, never a stale copy
  assign rdr_frame_o    = rdr_valid_o ? tape[tp] : ~tape[tp];
  assign pun_ready_o    = ok;
  assign mem_wr_ready_o = ok;

  task automatic load(input int n);
    tp = 0;
    tn = n;
    ri = 0;
    mn = 0;
    pn = 0;
  endtask

  initial begin
    foreach (tape[i]) tape[i] = 8'h00;
    load(0);
    slow           = 1'b0;
    cyc            = 2'h0;
    mem_rd_valid_o = 1'b0;
    mem_rd_data_o  = 48'h0;
  end

  always @(posedge mclk_i) begin
    cyc <= cyc + 2'h1;
    if (rdr_valid_o && rdr_ready_i) tp <= tp + 1;
    if (pun_valid_i && pun_ready_o) begin
      pf[pn] <= pun_frame_i;
      pn     <= pn + 1;
    end
    if (mem_wr_valid_i && mem_wr_ready_o) begin
      mw[mn] <= mem_wr_data_i;
      mn     <= mn + 1;
    end
    if (mem_rd_valid_o) begin
      mem_rd_valid_o <= 1'b0;
      mem_rd_data_o  <= ~mem_rd_data_o;
      ri             <= ri + 1;
    end else if (mem_rd_req_i && ok) begin
      mem_rd_valid_o <= 1'b1;
      mem_rd_data_o  <= src[ri];
    end
  end
endmodule // ptc_far

// ===== bench/ptc_word_ctrl_tb.sv
// self-checking bench of the paper tape word controller
// assumes the far side model is compiled before it
`timescale 1ns/1ps
`include "ptc_params.svh"
module ptc_word_ctrl_tb import ptc_pkg::*;;
  logic        mclk_i, rst_i, ce_i, reg_wr_i, reg_rd_i, mech_avail_i;
  logic [7:0]  reg_addr_i, rdr_frame_i, pun_frame_o;
  logic [31:0] reg_wdata_i, reg_rdata_o, v;
  logic        rdr_valid_i, rdr_ready_o, pun_valid_o, pun_ready_i;
  logic        mem_wr_valid_o, mem_wr_ready_i, mem_rd_req_o, mem_rd_valid_i;
  logic [47:0] mem_wr_data_o, mem_rd_data_i, w;
  int          err_total, checked;
  typedef struct packed {
    logic        pu;
    logic [3:0]  c;
    logic [47:0] d;
  } ptc_row_t;
  ptc_row_t rows [8] = '{'{1'b0, 4'h0, 48'hF5}, '{1'b0, 4'h1, 48'h2B},
    '{1'b0, 4'h2, 48'h6B}, '{1'b0, 4'h3, 48'hC5}, '{1'b1, 4'h1, 48'h0123456789AB},
    '{1'b1, 4'h2, 48'h0123456789AB}, '{1'b1, 4'h3, 48'hFC0FFF03F000},
    '{1'b1, 4'h0, 48'hFC0FFF03F000}};

  ptc_word_ctrl ptc_word_ctrl_inst (.mclk_i, .rst_i, .ce_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .mech_avail_i, .rdr_valid_i, .rdr_frame_i,
    .rdr_ready_o, .pun_valid_o, .pun_frame_o, .pun_ready_i, .mem_wr_valid_o,
    .mem_wr_data_o, .mem_wr_ready_i, .mem_rd_req_o, .mem_rd_valid_i, .mem_rd_data_i);
  ptc_far ptc_far_inst (.mclk_i, .rdr_valid_o(rdr_valid_i), .rdr_frame_o(rdr_frame_i),
    .rdr_ready_i(rdr_ready_o), .pun_valid_i(pun_valid_o), .pun_frame_i(pun_frame_o),
    .pun_ready_o(pun_ready_i), .mem_wr_valid_i(mem_wr_valid_o),
    .mem_wr_data_i(mem_wr_data_o), .mem_wr_ready_o(mem_wr_ready_i),
    .mem_rd_req_i(mem_rd_req_o), .mem_rd_valid_o(mem_rd_valid_i),
    .mem_rd_data_o(mem_rd_data_i));

  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  // ======
  // tasks
  task automatic chk(input logic [47:0] e, input logic [47:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic complete_run();
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask
  // leaves the final status word in v
  task automatic idle();
    for (int i = 0; i < 400; i++) begin
      rd(`PTC_OFS_STATUS);
      if (v[`PTC_ST_BUSY] === 1'b0) return;
    end
    err_total++;
    complete_run();
  endtask
  task automatic go(input logic [3:0] c, input logic [8:0] o, input int n);
    ptc_far_inst.load(n);
    wr(`PTC_OFS_CTRL, {28'h0, c});
    wr(`PTC_OFS_ORDER, {23'h0, o});
  endtask

  // ======
  // main sequence
  initial begin
    err_total    = 0;
    checked      = 0;
    rst_i        = 1'b1;
    ce_i         = 1'b1;
    reg_wr_i     = 1'b0;
    reg_rd_i     = 1'b0;
    mech_avail_i = 1'b1;
    reg_addr_i   = 8'h00;
    reg_wdata_i  = 32'h0;
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    foreach (rows[k]) begin
      if (rows[k].pu) begin
        ptc_far_inst.src[0] = rows[k].d;
        go(rows[k].c, 9'h101, 0);
        idle();
        for (int i = 0; i < 8; i++) begin
          w = {42'h0, rows[k].d[47-6*i -: 6]};
          if (rows[k].c[1:0] == PTC_MODE_SEVEN) w[6] = ~^w[5:0];
          // five-level tape has no sixth channel
          if (rows[k].c[1:0] == PTC_MODE_FIVE) w[5] = 1'b0;
          chk(w, {40'h0, ptc_far_inst.pf[i]});
        end
      end else begin
        ptc_far_inst.tape[0] = 8'h00;
        for (int i = 1; i < 9; i++) ptc_far_inst.tape[i] = rows[k].d[7:0];
        go(rows[k].c, 9'h001, 9);
        idle();
        w = {8{(rows[k].c[1:0] == PTC_MODE_FIVE) ? {1'b0, rows[k].d[4:0]} : rows[k].d[5:0]}};
        if (rows[k].c[1:0] == PTC_MODE_EIGHT) w = {4{4'h0, rows[k].d[7:0]}};
        chk(w, ptc_far_inst.mw[0]);
      end
      chk(48'h2, {46'h0, v[1:0]});
    end
    // bad parity with stop setting: no store, fault latched, then reset clears all
    ptc_far_inst.tape[0] = 8'h6B;
    ptc_far_inst.tape[1] = 8'h2B;
    go(4'h2, 9'h001, 2);
    idle();
    chk(48'h0, 48'(ptc_far_inst.mn));
    rd(`PTC_OFS_FAULT);
    chk(48'h1, {47'h0, v[0]});
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(`PTC_OFS_FAULT);
    chk(48'h0, {16'h0, v});
    rd(`PTC_OFS_CTRL);
    chk(48'h0, {16'h0, v});
    rd(8'h10);
    chk(48'h0, {16'h0, v});
    // frozen clock enable: a control write must not land
    @(posedge mclk_i);
    ce_i <= 1'b0;
    wr(`PTC_OFS_CTRL, 32'h0000_000F);
    ce_i <= 1'b1;
    rd(`PTC_OFS_CTRL);
    chk(48'h0, {16'h0, v});
    for (int i = 0; i < 8; i++) ptc_far_inst.tape[i] = 8'h2B;
    go(4'hA, 9'h001, 8);
    idle();
    chk({8{6'h2B}}, ptc_far_inst.mw[0]);
    rd(`PTC_OFS_FAULT);
    chk(48'h1, {47'h0, v[0]});
    // stop in fourth place of a two-word order, slow reader and memory
    for (int i = 0; i < 8; i++) ptc_far_inst.tape[i] = (i == 3) ? 8'h3A : 8'h01 + 8'(i);
    ptc_far_inst.slow = 1'b1;
    go(4'h1, 9'h002, 8);
    idle();
    ptc_far_inst.slow = 1'b0;
    chk(48'h0, {46'h0, v[1:0]});
    chk(48'h420FA, ptc_far_inst.mw[0]);
    chk(48'h1, 48'(ptc_far_inst.mn));
    rd(`PTC_OFS_FAULT);
    chk(48'h0, {47'h0, v[0]});
    for (int i = 0; i < 8; i++) ptc_far_inst.tape[i] = 8'h3A;
    go(4'h5, 9'h001, 8);
    idle();
    chk({8{6'h3A}}, ptc_far_inst.mw[0]);
    @(posedge mclk_i);
    mech_avail_i <= 1'b0;
    wr(`PTC_OFS_ORDER, 32'h101);
    rd(`PTC_OFS_ORDER);
    chk(48'h1, {47'h0, v[0]});
    @(posedge mclk_i);
    mech_avail_i <= 1'b1;
    // stalled two-word punch, second order while busy
    ptc_far_inst.slow   = 1'b1;
    ptc_far_inst.src[0] = 48'h111111111111;
    ptc_far_inst.src[1] = 48'hFFFFFFFFFFFF;
    go(4'h1, 9'h102, 0);
    wr(`PTC_OFS_ORDER, 32'h001);
    rd(`PTC_OFS_ORDER);
    chk(48'h1, {47'h0, v[0]});
    idle();
    chk(48'h10, 48'(ptc_far_inst.pn));
    chk(48'h3F, {40'h0, ptc_far_inst.pf[15]});
    complete_run();
  end
endmodule // ptc_word_ctrl_tb
